// ===== logic/alert_pkg.sv
// Purpose: constants for the process value alert monitor
// Assumes: 32-bit AXI4-Lite register bus, one word per register
// Notes:   currents are given in microamps
package alert_pkg;
    // register byte offsets
    localparam logic [5:0] CTRL_OFS     = 6'h00;
    localparam logic [5:0] POLL_OFS     = 6'h04;
    localparam logic [5:0] HYST_OFS     = 6'h08;
    localparam logic [5:0] THR_OH_OFS   = 6'h0C;
    localparam logic [5:0] THR_IH_OFS   = 6'h10;
    localparam logic [5:0] THR_IL_OFS   = 6'h14;
    localparam logic [5:0] THR_OL_OFS   = 6'h18;
    localparam logic [5:0] STAT_OFS     = 6'h1C;
    localparam logic [5:0] IRQ_STAT_OFS = 6'h20;
    localparam logic [5:0] IRQ_CLR_OFS  = 6'h24;
    localparam logic [5:0] IRQ_EN_OFS   = 6'h28;
    localparam logic [3:0] LAST_IDX     = 4'hA;
    localparam logic [3:0] NO_IDX       = 4'hF;

    // alert order: enable bits, status bits, event bits
    localparam int AL_OH = 0;
    localparam int AL_IH = 1;
    localparam int AL_IL = 2;
    localparam int AL_OL = 3;
    localparam int NUM_AL = 4;

    // control and status fields
    localparam int CTRL_REV_BIT   = 4;
    localparam int STAT_JMP_BIT   = 4;
    localparam int STAT_HW_BIT    = 5;
    localparam int STAT_MODE_LSB  = 6;
    localparam int EV_REJECT_BIT  = 4;
    localparam int NUM_EV         = 5;

    // reset values
    localparam logic [4:0]  CTRL_RST   = 5'h00;
    localparam logic [3:0]  POLL_RST   = 4'h0;
    localparam logic [3:0]  POLL_MAX   = 4'hF;
    localparam logic [15:0] HYST_RST   = 16'h0000;
    localparam logic [15:0] THR_HI_RST = 16'h7FFF;
    localparam logic [15:0] THR_LO_RST = 16'h8000;
    localparam logic [4:0]  IRQ_RST    = 5'h00;

    // loop currents in microamps
    localparam logic [15:0] CUR_LOW_UA   = 16'h0EA6;
    localparam logic [15:0] CUR_HIGH_UA  = 16'h57E4;
    localparam logic [15:0] CUR_FIXED_UA = 16'h0FA0;

    typedef enum logic [1:0] {
        LOOP_NORMAL = 2'b00,
        LOOP_LOW    = 2'b01,
        LOOP_HIGH   = 2'b10,
        LOOP_FIXED  = 2'b11
    } loop_mode_e;
endpackage : alert_pkg

// ===== logic/process_value_alert_monitor.sv
// Purpose: four-threshold process value alerts with loop alarm forcing
// Assumes: process value samples arrive on aclk with a one-cycle strobe
// Notes:   jumper and hardware fault pins are synchronised
//
// Function
// - enabled outer high alert sets when value rises above its threshold
// - outer high alert clears once value is threshold minus deadband
// - enabled inner high alert sets when value rises above its threshold
// - inner high alert clears once value is threshold minus deadband
// - enabled inner low alert sets when value falls below its threshold
// - inner low alert clears once value is threshold plus deadband
// - enabled outer low alert sets when value falls below its threshold
// - outer low alert clears once value is threshold plus deadband
// - each alert compares only while its own enable is on
// - one shared deadband serves as hysteresis for all four alerts
// - tripped outer high alert forces loop to jumper-chosen alarm current
// - tripped outer low alert forces loop to jumper-chosen alarm current
// - direct action: high setting reads very high; reverse swaps it
// - non-zero polling address suppresses process value alarm currents
// - polling address 0 to 15; above 0 holds loop current fixed unless a hardware fault forces alarm level
// - hardware faults force alarm level even with outer alerts off
// - new inner thresholds are checked against the others for overlap
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module process_value_alert_monitor #(
    parameter int PV_W = 16
) (
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi4-lite write address
    input  wire logic [5:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // axi4-lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read address
    input  wire logic [5:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // axi4-lite read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // process value samples
    input  wire logic [PV_W-1:0]   process_value,
    input  wire logic              process_value_valid,
    // pins
    input  wire logic              alarm_jumper_high,
    input  wire logic              hw_fault,
    // loop output and alerts
    output logic [1:0]             loop_mode,
    output logic [15:0]            loop_current_ua,
    output logic [alert_pkg::NUM_AL-1:0] alerts,
    output logic                   irq
);
    localparam int NUM_AL_P = alert_pkg::NUM_AL;

    if (PV_W < 2 || PV_W > 16) begin : g_bad_width
        $error("PV_W must be between 2 and 16");
    end

    // register word index, or none for unmapped
    function automatic logic [3:0] reg_idx(input logic [5:0] a);
        reg_idx = (a[5:2] <= alert_pkg::LAST_IDX) ? a[5:2]
                                                  : alert_pkg::NO_IDX;
    endfunction : reg_idx

    // byte-lane merge of write data
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  st);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                merge[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
    endfunction : merge

    logic [4:0]                ctrl_reg;
    logic [3:0]                poll_reg;
    logic [PV_W-1:0]           hyst_reg;
    logic [PV_W-1:0]           thr_reg [alert_pkg::NUM_AL];
    logic [alert_pkg::NUM_EV-1:0] irq_stat_reg;
    logic [alert_pkg::NUM_EV-1:0] irq_en_reg;
    logic [NUM_AL_P-1:0]       alert_q_reg;
    logic [NUM_AL_P-1:0]       alert_bits;
    logic                      jmp_s1_reg;
    logic                      jmp_s2_reg;
    logic                      hw_s1_reg;
    logic                      hw_s2_reg;
    logic                      aw_full_reg;
    logic                      w_full_reg;
    logic [5:0]                aw_addr_reg;
    logic [31:0]               w_data_reg;
    logic [3:0]                w_strb_reg;
    logic                      do_write;
    logic [3:0]                widx;
    logic [31:0]               wword;
    logic                      reject;
    logic                      clr_we;
    logic [alert_pkg::NUM_EV-1:0] events;
    logic signed [PV_W:0]      cand;

    // pin synchronisers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            jmp_s1_reg <= 1'b0;
            jmp_s2_reg <= 1'b0;
            hw_s1_reg  <= 1'b0;
            hw_s2_reg  <= 1'b0;
        end else begin
            jmp_s1_reg <= alarm_jumper_high;
            jmp_s2_reg <= jmp_s1_reg;
            hw_s1_reg  <= hw_fault;
            hw_s2_reg  <= hw_s1_reg;
        end
    end

    // write channel capture
    assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
    assign do_write      = aw_full_reg && w_full_reg && !s_axi_bvalid;
    assign widx          = reg_idx(aw_addr_reg);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg  <= 1'b0;
            w_full_reg   <= 1'b0;
            aw_addr_reg  <= 6'h00;
            w_data_reg   <= 32'h00000000;
            w_strb_reg   <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_full_reg  <= 1'b0;
                w_full_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (widx == alert_pkg::NO_IDX) ? 2'b10 : 2'b00;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // candidate word and inner threshold overlap check
    always_comb begin
        wword  = 32'h00000000;
        reject = 1'b0;
        case (widx)
            alert_pkg::THR_IH_OFS[5:2]: begin
                wword = merge({{(32-PV_W){1'b0}}, thr_reg[alert_pkg::AL_IH]},
                              w_data_reg, w_strb_reg);
            end
            alert_pkg::THR_IL_OFS[5:2]: begin
                wword = merge({{(32-PV_W){1'b0}}, thr_reg[alert_pkg::AL_IL]},
                              w_data_reg, w_strb_reg);
            end
            default: begin
                wword = merge(32'h00000000, w_data_reg, w_strb_reg);
            end
        endcase
        cand = {wword[PV_W-1], wword[PV_W-1:0]};
        if (widx == alert_pkg::THR_IH_OFS[5:2]) begin
            reject = (cand > $signed({thr_reg[alert_pkg::AL_OH][PV_W-1],
                                      thr_reg[alert_pkg::AL_OH]}))
                  || (cand < $signed({thr_reg[alert_pkg::AL_IL][PV_W-1],
                                      thr_reg[alert_pkg::AL_IL]}));
        end else if (widx == alert_pkg::THR_IL_OFS[5:2]) begin
            reject = (cand < $signed({thr_reg[alert_pkg::AL_OL][PV_W-1],
                                      thr_reg[alert_pkg::AL_OL]}))
                  || (cand > $signed({thr_reg[alert_pkg::AL_IH][PV_W-1],
                                      thr_reg[alert_pkg::AL_IH]}));
        end
    end

    // configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg   <= alert_pkg::CTRL_RST;
            poll_reg   <= alert_pkg::POLL_RST;
            hyst_reg   <= alert_pkg::HYST_RST[PV_W-1:0];
            irq_en_reg <= alert_pkg::IRQ_RST;
            thr_reg[alert_pkg::AL_OH] <= alert_pkg::THR_HI_RST[15 -: PV_W];
            thr_reg[alert_pkg::AL_IH] <= alert_pkg::THR_HI_RST[15 -: PV_W];
            thr_reg[alert_pkg::AL_IL] <= alert_pkg::THR_LO_RST[15 -: PV_W];
            thr_reg[alert_pkg::AL_OL] <= alert_pkg::THR_LO_RST[15 -: PV_W];
        end else if (do_write) begin
            case (widx)
                alert_pkg::CTRL_OFS[5:2]:   ctrl_reg <= wword[4:0];
                alert_pkg::POLL_OFS[5:2]:   poll_reg <= wword[3:0];
                alert_pkg::HYST_OFS[5:2]:   hyst_reg <= wword[PV_W-1:0];
                alert_pkg::IRQ_EN_OFS[5:2]: irq_en_reg <= wword[4:0];
                alert_pkg::THR_OH_OFS[5:2]: begin
                    thr_reg[alert_pkg::AL_OH] <= wword[PV_W-1:0];
                end
                alert_pkg::THR_IH_OFS[5:2]: begin
                    if (!reject) begin
                        thr_reg[alert_pkg::AL_IH] <= wword[PV_W-1:0];
                    end
                end
                alert_pkg::THR_IL_OFS[5:2]: begin
                    if (!reject) begin
                        thr_reg[alert_pkg::AL_IL] <= wword[PV_W-1:0];
                    end
                end
                alert_pkg::THR_OL_OFS[5:2]: begin
                    thr_reg[alert_pkg::AL_OL] <= wword[PV_W-1:0];
                end
                default: ;
            endcase
        end
    end

    // per-alert compare with shared deadband
    for (genvar g = 0; g < NUM_AL_P; g++) begin : g_alert
        localparam bit IS_HIGH = (g < 2);
        logic                  alert_reg;
        logic signed [PV_W+1:0] pv_x;
        logic signed [PV_W+1:0] thr_x;
        logic signed [PV_W+1:0] hy_x;

        assign pv_x  = {{2{process_value[PV_W-1]}}, process_value};
        assign thr_x = {{2{thr_reg[g][PV_W-1]}}, thr_reg[g]};
        assign hy_x  = {2'b00, hyst_reg};
        assign alert_bits[g] = alert_reg;

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                alert_reg <= 1'b0;
            end else if (!ctrl_reg[g]) begin
                alert_reg <= 1'b0;
            end else if (process_value_valid) begin
                if (IS_HIGH) begin
                    if (pv_x > thr_x) begin
                        alert_reg <= 1'b1;
                    end else if (pv_x <= thr_x - hy_x) begin
                        alert_reg <= 1'b0;
                    end
                end else begin
                    if (pv_x < thr_x) begin
                        alert_reg <= 1'b1;
                    end else if (pv_x >= thr_x + hy_x) begin
                        alert_reg <= 1'b0;
                    end
                end
            end
        end
    end

    assign alerts = alert_bits;

    // sticky interrupt status, set wins over clear
    assign clr_we = do_write && (widx == alert_pkg::IRQ_CLR_OFS[5:2]);
    assign events = {do_write && reject, alert_bits & ~alert_q_reg};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alert_q_reg  <= '0;
            irq_stat_reg <= alert_pkg::IRQ_RST;
            irq          <= 1'b0;
        end else begin
            alert_q_reg  <= alert_bits;
            irq_stat_reg <= (irq_stat_reg & ~(clr_we ? wword[4:0] : 5'h00))
                          | events;
            irq          <= |(irq_stat_reg & irq_en_reg);
        end
    end

    // loop output selection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            loop_mode       <= alert_pkg::LOOP_NORMAL;
            loop_current_ua <= 16'h0000;
        end else if (hw_s2_reg
                 || (poll_reg == 4'h0
                 && (alert_bits[alert_pkg::AL_OH]
                 ||  alert_bits[alert_pkg::AL_OL]))) begin
            if (jmp_s2_reg ^ ctrl_reg[alert_pkg::CTRL_REV_BIT]) begin
                loop_mode       <= alert_pkg::LOOP_HIGH;
                loop_current_ua <= alert_pkg::CUR_HIGH_UA;
            end else begin
                loop_mode       <= alert_pkg::LOOP_LOW;
                loop_current_ua <= alert_pkg::CUR_LOW_UA;
            end
        end else if (poll_reg != 4'h0) begin
            loop_mode       <= alert_pkg::LOOP_FIXED;
            loop_current_ua <= alert_pkg::CUR_FIXED_UA;
        end else begin
            loop_mode       <= alert_pkg::LOOP_NORMAL;
            loop_current_ua <= 16'h0000;
        end
    end

    // read channel
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            s_axi_rdata  <= 32'h00000000;
            case (reg_idx(s_axi_araddr))
                alert_pkg::CTRL_OFS[5:2]: s_axi_rdata[4:0] <= ctrl_reg;
                alert_pkg::POLL_OFS[5:2]: s_axi_rdata[3:0] <= poll_reg;
                alert_pkg::HYST_OFS[5:2]: s_axi_rdata[PV_W-1:0] <= hyst_reg;
                alert_pkg::THR_OH_OFS[5:2]: begin
                    s_axi_rdata[PV_W-1:0] <= thr_reg[alert_pkg::AL_OH];
                end
                alert_pkg::THR_IH_OFS[5:2]: begin
                    s_axi_rdata[PV_W-1:0] <= thr_reg[alert_pkg::AL_IH];
                end
                alert_pkg::THR_IL_OFS[5:2]: begin
                    s_axi_rdata[PV_W-1:0] <= thr_reg[alert_pkg::AL_IL];
                end
                alert_pkg::THR_OL_OFS[5:2]: begin
                    s_axi_rdata[PV_W-1:0] <= thr_reg[alert_pkg::AL_OL];
                end
                alert_pkg::STAT_OFS[5:2]: begin
                    s_axi_rdata[7:0] <= {loop_mode, hw_s2_reg,
                                         jmp_s2_reg, alert_bits};
                end
                alert_pkg::IRQ_STAT_OFS[5:2]: begin
                    s_axi_rdata[4:0] <= irq_stat_reg;
                end
                alert_pkg::IRQ_EN_OFS[5:2]: s_axi_rdata[4:0] <= irq_en_reg;
                alert_pkg::IRQ_CLR_OFS[5:2]: ;
                default: s_axi_rresp <= 2'b10;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule : process_value_alert_monitor

// ===== test/alert_monitor_sva.sv
// Purpose: port assertions for the alert monitor
// Assumes: alert and loop latencies as handed over
// Notes:   bound to every monitor instance
`timescale 1ns/1ps
module alert_monitor_sva (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // register bus
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // samples, pins and outputs
    input wire logic        process_value_valid,
    input wire logic        hw_fault,
    input wire logic [1:0]  loop_mode,
    input wire logic [15:0] loop_current_ua,
    input wire logic [3:0]  alerts
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    rst_clear_a: assert property (disable iff (1'b0)
        !aresetn |=> alerts == 4'h0 && loop_mode == 2'h0)
        else $error("alerts or loop not cleared by reset");
    oh_rise_a: assert property ($rose(alerts[0])
        |-> $past(process_value_valid)) else $error("outer high set unsampled");
    ih_rise_a: assert property ($rose(alerts[1])
        |-> $past(process_value_valid)) else $error("inner high set unsampled");
    il_rise_a: assert property ($rose(alerts[2])
        |-> $past(process_value_valid)) else $error("inner low set unsampled");
    ol_rise_a: assert property ($rose(alerts[3])
        |-> $past(process_value_valid)) else $error("outer low set unsampled");
    hw_alarm_a: assert property (hw_fault [*4] |=>
        loop_mode inside {alert_pkg::LOOP_LOW, alert_pkg::LOOP_HIGH})
        else $error("hardware fault gave no alarm current");
    cur_code_a: assert property (loop_current_ua ==
        (loop_mode == alert_pkg::LOOP_HIGH ? alert_pkg::CUR_HIGH_UA :
         loop_mode == alert_pkg::LOOP_LOW ? alert_pkg::CUR_LOW_UA :
         loop_mode == alert_pkg::LOOP_FIXED ? alert_pkg::CUR_FIXED_UA :
         16'h0000)) else $error("loop current does not match mode");
    outer_alarm_a: assert property (alerts[0] || alerts[3]
        |=> loop_mode != alert_pkg::LOOP_NORMAL)
        else $error("outer alert left loop normal");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    r_answer_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer late");

    cover property (alerts == 4'hC);
    cover property (loop_mode == alert_pkg::LOOP_FIXED);
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : alert_monitor_sva

bind process_value_alert_monitor alert_monitor_sva sva_i (.aclk, .aresetn,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .process_value_valid, .hw_fault, .loop_mode, .loop_current_ua, .alerts);

// ===== test/loop_receiver.sv
// Purpose: current loop receiver reading the monitor's output
// Assumes: loop current given in microamps
// Notes:   reading 0 live, 1 very low, 2 very high, 3 fixed
`timescale 1ns/1ps
module loop_receiver (
    // loop
    input  wire logic [15:0] loop_current_ua,
    // decoded reading
    output logic [1:0]       reading
);
    always_comb begin
        if (loop_current_ua == alert_pkg::CUR_FIXED_UA) begin
            reading = 2'h3;
        end else if (loop_current_ua == 16'h0000) begin
            reading = 2'h0;
        end else if (loop_current_ua < alert_pkg::CUR_FIXED_UA) begin
            reading = 2'h1;
        end else if (loop_current_ua > 16'h4E20) begin
            reading = 2'h2;
        end else begin
            reading = 2'h0;
        end
    end
endmodule : loop_receiver

// ===== test/testbench.sv
// Purpose: register and sample driven test of the alert monitor
// Assumes: design answers bus requests as handed over
// Notes:   loop receiver decodes the analog output
`timescale 1ns/1ps
module testbench;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_arready, s_axi_rvalid, s_axi_rready, irq, hw_fault;
    logic        process_value_valid, alarm_jumper_high;
    logic [5:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb, alerts;
    logic [1:0]  s_axi_bresp, s_axi_rresp, loop_mode, reading, rs;
    logic [15:0] process_value, loop_current_ua;
    int          mismatches, checked;
    logic [15:0] pv_tab [13] = '{16'h0000, 16'h0033, 16'h0064, 16'h0065,
        16'h005B, 16'h005A, 16'h0028, 16'hFFCD, 16'hFF9C, 16'hFF9B,
        16'hFFA5, 16'hFFA6, 16'hFFD8};
    logic [3:0]  al_tab [13] = '{4'h0, 4'h2, 4'h2, 4'h3, 4'h3, 4'h2, 4'h0,
        4'h4, 4'h4, 4'hC, 4'hC, 4'h4, 4'h0};

    process_value_alert_monitor process_value_alert_monitor_i (.aclk,
        .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .process_value, .process_value_valid,
        .alarm_jumper_high, .hw_fault, .loop_mode, .loop_current_ua, .alerts,
        .irq);
    loop_receiver loop_receiver_i (.loop_current_ua, .reading);

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask : tick

    task automatic give_verdict();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        rs = 2'h3;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (rs == 2'h3) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                rs = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end else if (s_axi_bvalid) s_axi_bready <= 1'b1;
        end
    endtask : wr

    task automatic rdr(input logic [5:0] a);
        rs = 2'h3;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        while (rs == 2'h3) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                rd = s_axi_rdata;
                rs = s_axi_rresp;
                s_axi_rready <= 1'b0;
            end else if (s_axi_rvalid) s_axi_rready <= 1'b1;
        end
    endtask : rdr

    task automatic smp(input logic [15:0] v);
        process_value <= v;
        process_value_valid <= 1'b1;
        @(posedge aclk);
        process_value_valid <= 1'b0;
        tick(4);
    endtask : smp

    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        give_verdict();
    end

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, process_value_valid, hw_fault} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 44'h0;
        s_axi_wstrb = 4'hF;
        process_value = 16'h0000;
        alarm_jumper_high = 1'b1;
        mismatches = 0;
        checked = 0;
        tick(2);
        aresetn <= 1'b1;
        tick(1);
        rdr(alert_pkg::CTRL_OFS);
        chk(rd, 32'h0);
        rdr(alert_pkg::THR_OH_OFS);
        chk(rd[15:0], alert_pkg::THR_HI_RST);
        rdr(6'h30);
        chk(rs, 2'h2);
        chk(rd, 32'h0);
        wr(6'h2C, 32'h1);
        chk(rs, 2'h2);
        // low thresholds kept below high ones
        wr(alert_pkg::HYST_OFS, 32'h0000000A);
        wr(alert_pkg::THR_OH_OFS, 32'h00000064);
        wr(alert_pkg::THR_IH_OFS, 32'h00000032);
        wr(alert_pkg::THR_IL_OFS, 32'h0000FFCE);
        wr(alert_pkg::THR_OL_OFS, 32'h0000FF9C);
        wr(alert_pkg::CTRL_OFS, 32'h0000000F);
        for (int i = 0; i < 13; i++) begin
            smp(pv_tab[i]);
            chk(alerts, al_tab[i]);
            rd = (al_tab[i][0] || al_tab[i][3]) ? 32'h1 : 32'h0;
            chk(loop_mode, rd[0] ? 2'h2 : 2'h0);
            chk(loop_current_ua, rd[0] ? 16'h57E4 : 16'h0);
            chk(reading, rd[0] ? 2'h2 : 2'h0);
        end
        rdr(alert_pkg::IRQ_STAT_OFS);
        chk(rd, 32'h0000000F);
        chk(irq, 1'b0);
        wr(alert_pkg::IRQ_EN_OFS, 32'h0000001F);
        tick(3);
        chk(irq, 1'b1);
        wr(alert_pkg::IRQ_CLR_OFS, 32'h0000000F);
        tick(3);
        chk(irq, 1'b0);
        wr(alert_pkg::THR_IH_OFS, 32'h000000C8);
        chk(rs, 2'h0);
        wr(alert_pkg::THR_IL_OFS, 32'h0000FF6A);
        rdr(alert_pkg::THR_IH_OFS);
        chk(rd[15:0], 16'h0032);
        rdr(alert_pkg::THR_IL_OFS);
        chk(rd[15:0], 16'hFFCE);
        rdr(alert_pkg::IRQ_STAT_OFS);
        chk(rd, 32'h00000010);
        chk(irq, 1'b1);
        wr(alert_pkg::CTRL_OFS, 32'h0000000E);
        smp(16'h00C8);
        chk(alerts, 4'h2);
        hw_fault <= 1'b1;
        tick(5);
        chk(loop_mode, 2'h2);
        wr(alert_pkg::CTRL_OFS, 32'h0000001E);
        tick(3);
        chk({loop_mode, loop_current_ua}, 18'h10EA6);
        chk(reading, 2'h1);
        rdr(alert_pkg::STAT_OFS);
        chk(rd, 32'h00000072);
        alarm_jumper_high <= 1'b0;
        tick(5);
        chk(loop_mode, 2'h2);
        hw_fault <= 1'b0;
        alarm_jumper_high <= 1'b1;
        wr(alert_pkg::POLL_OFS, 32'h0000000F);
        wr(alert_pkg::CTRL_OFS, 32'h0000000F);
        smp(16'h00C8);
        chk(alerts, 4'h3);
        chk({loop_mode, loop_current_ua}, 18'h30FA0);
        chk(reading, 2'h3);
        wr(alert_pkg::POLL_OFS, 32'h00000000);
        tick(3);
        chk(loop_mode, 2'h2);
        aresetn <= 1'b0;
        tick(2);
        aresetn <= 1'b1;
        tick(1);
        chk({alerts, loop_mode}, 6'h00);
        give_verdict();
    end
endmodule : testbench
